/* vrm_core.sv */
/*
  Issue core of the five-slot VLIW model: instruction issue, register
  file, branch delay handling, status word, branch-target latches and
  the cycle tally with its snapshot.
  Assumes i_instr holds the instruction at o_pc, memory answers each
  load request in the same cycle, and all inputs are synchronous.
*/
`timescale 1ns/1ps
`include "vrm_regs.svh"

module vrm_core
  import vrm_pkg::*;
#(
  parameter int SLOTS = `VRM_SLOTS
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rstn,
  input  wire vrm_slot_s [SLOTS-1:0]         i_instr,
  input  wire logic                          i_stall,
  input  wire logic                          i_exc_req,
  input  wire logic [SLOTS-1:0][`VRM_DW-1:0] i_mem_data,
  input  wire vrm_sw_s                       i_sw,
  input  wire logic [`VRM_RA_W-1:0]          i_dbg_addr,
  output vrm_mem_s  [SLOTS-1:0]              o_mem_req,
  output logic      [`VRM_DW-1:0]            o_pc,
  output logic      [`VRM_DW-1:0]            o_psw,
  output logic      [`VRM_DW-1:0]            o_resume_target,
  output logic      [`VRM_DW-1:0]            o_block_start,
  output logic      [`VRM_TW-1:0]            o_tally_snap,
  output logic      [`VRM_TW-1:0]            o_tally_live,
  output logic                               o_jump_done,
  output logic                               o_exc_taken,
  output logic      [`VRM_DW-1:0]            o_dbg_data
);

  localparam int NRD = 3 * SLOTS + 1;
  localparam int NWR = 2 * SLOTS;
  localparam logic [1:0] DLY_LAST = 2'(`VRM_BR_DELAY - 1);

  // ========================================================
  // Declarations
  logic      [NRD-1:0][`VRM_RA_W-1:0] raddr;
  logic      [NRD-1:0][`VRM_DW-1:0]   rdata;
  vrm_wb_s   [NWR-1:0]                wb;
  vrm_br_s   [SLOTS-1:0]              br;
  logic                               issue;
  logic                               br_hit;
  logic      [`VRM_DW-1:0]            br_tgt;
  logic                               jump_now;
  logic      [`VRM_WB_CNT_W-1:0]      wb_cnt;
  vrm_br_state_e                      state;
  vrm_br_state_e                      next_state;
  logic      [1:0]                    dcnt;
  logic      [1:0]                    next_dcnt;
  logic      [`VRM_DW-1:0]            tgt;
  logic      [`VRM_DW-1:0]            next_tgt;
  logic      [`VRM_DW-1:0]            next_pc;
  logic      [`VRM_DW-1:0]            next_psw;
  logic      [`VRM_DW-1:0]            next_resume_target;
  logic      [`VRM_DW-1:0]            next_block_start;
  logic      [`VRM_TW-1:0]            next_tally_snap;
  logic      [`VRM_TW-1:0]            next_tally_live;
  logic                               next_jump_done;
  logic                               next_exc_taken;
  logic      [`VRM_DW-1:0]            next_dbg_data;

  // ========================================================
  // Issue: one instruction per unstalled cycle
  assign issue = !i_stall;

  // ========================================================
  // Register read addresses: guard, operand a, operand b per slot
  always_comb begin
    for (int s = 0; s < SLOTS; s++) begin
      raddr[3*s]     = i_instr[s].guard;
      raddr[3*s + 1] = i_instr[s].src_a;
      raddr[3*s + 2] = i_instr[s].src_b;
    end
    raddr[3*SLOTS] = i_dbg_addr;
  end

  vrm_regfile #(
    .NRD (NRD),
    .NWR (NWR)
  ) u_regfile (
    .i_clk   (i_clk),
    .i_raddr (raddr),
    .i_wb    (wb),
    .o_rdata (rdata)
  );

  // ========================================================
  // Operation slots
  for (genvar s = 0; s < SLOTS; s++) begin : g_slot
    vrm_slot u_slot (
      .i_clk      (i_clk),
      .i_rstn     (i_rstn),
      .i_issue    (issue),
      .i_slot     (i_instr[s]),
      .i_guard    (rdata[3*s]),
      .i_opa      (rdata[3*s + 1]),
      .i_opb      (rdata[3*s + 2]),
      .i_mem_data (i_mem_data[s]),
      .o_wb_add   (wb[2*s]),
      .o_wb_ld    (wb[2*s + 1]),
      .o_mem_req  (o_mem_req[s]),
      .o_br       (br[s])
    );
  end

  // ========================================================
  // Branch select: lowest-numbered taken slot wins
  always_comb begin
    br_hit = 1'b0;
    br_tgt = '0;
    for (int s = 0; s < SLOTS; s++) begin
      if (br[s].taken && !br_hit) begin
        br_hit = 1'b1;
        br_tgt = br[s].target;
      end
    end
  end

  // ========================================================
  // Write-back count for the status word
  always_comb begin
    wb_cnt = '0;
    for (int w = 0; w < NWR; w++) begin
      wb_cnt = wb_cnt + `VRM_WB_CNT_W'(wb[w].en);
    end
  end

  // ========================================================
  // Branch delay: three issued instructions follow a taken jump
  always_comb begin
    next_state = state;
    next_dcnt  = dcnt;
    next_tgt   = tgt;
    jump_now   = 1'b0;
    unique case (state)
      VRM_BR_IDLE: begin
        if (issue && br_hit) begin
          next_state = VRM_BR_DELAY;
          next_dcnt  = '0;
          next_tgt   = br_tgt;
        end
      end
      VRM_BR_DELAY: begin
        if (issue) begin
          if (dcnt == DLY_LAST) begin
            jump_now   = 1'b1;
            next_state = VRM_BR_IDLE;
          end else begin
            next_dcnt = dcnt + 2'h1;
          end
        end
      end
    endcase
  end

  // ========================================================
  // Branch delay registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= VRM_BR_IDLE;
      dcnt  <= '0;
      tgt   <= '0;
    end else begin
      state <= next_state;
      dcnt  <= next_dcnt;
      tgt   <= next_tgt;
    end
  end

  // ========================================================
  // Program counter, jump pulses, target latches, snapshot
  always_comb begin
    next_pc            = o_pc;
    next_resume_target = o_resume_target;
    next_block_start   = o_block_start;
    next_tally_snap    = o_tally_snap;
    next_jump_done     = 1'b0;
    next_exc_taken     = 1'b0;
    if (issue) begin
      next_pc = o_pc + `VRM_INSTR_BYTES;
    end
    if (jump_now) begin
      next_resume_target = tgt;
      if (i_exc_req) begin
        next_pc        = `VRM_EXC_VECTOR;
        next_exc_taken = 1'b1;
      end else begin
        next_pc          = tgt;
        next_block_start = tgt;
        next_tally_snap  = o_tally_live;
        next_jump_done   = 1'b1;
      end
    end
    if (i_sw.wr_resume) begin
      next_resume_target = i_sw.data;
    end
    if (i_sw.wr_block) begin
      next_block_start = i_sw.data;
    end
  end

  // ========================================================
  // Program counter and latch registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pc            <= `VRM_PC_RESET;
      o_resume_target <= '0;
      o_block_start   <= '0;
      o_tally_snap    <= '0;
      o_jump_done     <= 1'b0;
      o_exc_taken     <= 1'b0;
    end else begin
      o_pc            <= next_pc;
      o_resume_target <= next_resume_target;
      o_block_start   <= next_block_start;
      o_tally_snap    <= next_tally_snap;
      o_jump_done     <= next_jump_done;
      o_exc_taken     <= next_exc_taken;
    end
  end

  // ========================================================
  // Status word: hardware error bit beats a software write
  always_comb begin
    next_psw = o_psw;
    if (i_sw.wr_psw) begin
      next_psw = i_sw.data;
    end
    if (wb_cnt > `VRM_WB_CNT_W'(`VRM_MAX_WB)) begin
      next_psw[`VRM_PSW_WBE_BIT] = 1'b1;
    end
  end

  // ========================================================
  // Status word register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_psw <= `VRM_PSW_RESET;
    end else begin
      o_psw <= next_psw;
    end
  end

  // ========================================================
  // Cycle tally: every cycle, or only issuing cycles
  always_comb begin
    next_tally_live = o_tally_live;
    if (o_psw[`VRM_PSW_CS_BIT] || !i_stall) begin
      next_tally_live = o_tally_live + 64'h1;
    end
  end

  // ========================================================
  // Cycle tally register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tally_live <= '0;
    end else begin
      o_tally_live <= next_tally_live;
    end
  end

  // ========================================================
  // Debug read of one general register
  always_comb begin
    next_dbg_data = rdata[3*SLOTS];
  end

  // ========================================================
  // Debug read register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dbg_data <= '0;
    end else begin
      o_dbg_data <= next_dbg_data;
    end
  end

endmodule

/* vrm_regs.svh */
/*
  Constants of the VLIW register and issue model: widths, register
  indexes, reset values and issue timing.
  Assumes it is included by vrm_pkg and the design modules by bare name.
*/
// Notes on behaviour
// - Register zero always reads as zero
// - Register one always reads as one
// - Provide 128 general registers of 32 bits
// - Hold PC, status, two latches, 64-bit tally
// - Resume latch takes target of interrupted jump
// - Block-start latch takes target of clean jump
// - Issue one five-slot instruction per cycle
// - Operation acts only when guard is true
// - Add result usable next cycle, not same
// - Word load result usable three cycles later
// - Taken branch has three delay slots
// - Word load reads memory at base plus displacement
// - Jump-if-false needs guard true, condition false
// - Tally counts all cycles or non-stall cycles
// - Resume latch always, block latch only uninterrupted
// - Software latch write beats hardware update
// - Software reads tally snapshot taken on clean jumps
`ifndef VRM_REGS_SVH
`define VRM_REGS_SVH

// ==========================================================
// Widths and sizes
`define VRM_DW          32
`define VRM_TW          64
`define VRM_RA_W        7
`define VRM_NREGS       128
`define VRM_SLOTS       5
`define VRM_WB_CNT_W    4

// ==========================================================
// Constant registers
`define VRM_ZERO_IDX    7'h00
`define VRM_ONE_IDX     7'h01
`define VRM_CONST_ZERO  32'h0000_0000
`define VRM_CONST_ONE   32'h0000_0001

// ==========================================================
// Reset values and status word fields
`define VRM_PC_RESET    32'h0000_0000
`define VRM_EXC_VECTOR  32'h0000_0100
`define VRM_PSW_RESET   32'h0000_0800
`define VRM_PSW_CS_BIT  11
`define VRM_PSW_WBE_BIT 10

// ==========================================================
// Issue timing
`define VRM_INSTR_BYTES 32'h0000_0004
`define VRM_BR_DELAY    3
`define VRM_MAX_WB      5

`endif

/* vrm_pkg.sv */
/*
  Types of the VLIW register and issue model: opcodes, slot layout,
  write-back, memory request and branch carriers.
  Assumes vrm_regs.svh is on the include path.
*/
`include "vrm_regs.svh"

package vrm_pkg;

  // ========================================================
  // Operations
  typedef enum logic [1:0] {
    VRM_NOP  = 2'b00,
    VRM_IADD = 2'b01,
    VRM_LDW  = 2'b10,
    VRM_JMPF = 2'b11
  } vrm_op_e;

  typedef enum logic {
    VRM_BR_IDLE  = 1'b0,
    VRM_BR_DELAY = 1'b1
  } vrm_br_state_e;

  // ========================================================
  // Carriers
  typedef struct packed {
    logic [`VRM_RA_W-1:0] guard;
    vrm_op_e              op;
    logic [`VRM_RA_W-1:0] src_a;
    logic [`VRM_RA_W-1:0] src_b;
    logic [`VRM_RA_W-1:0] dest;
    logic [`VRM_DW-1:0]   imm;
  } vrm_slot_s;

  typedef struct packed {
    logic                 en;
    logic [`VRM_RA_W-1:0] addr;
    logic [`VRM_DW-1:0]   data;
  } vrm_wb_s;

  typedef struct packed {
    logic               valid;
    logic [`VRM_DW-1:0] addr;
  } vrm_mem_s;

  typedef struct packed {
    logic               taken;
    logic [`VRM_DW-1:0] target;
  } vrm_br_s;

  typedef struct packed {
    logic               wr_psw;
    logic               wr_resume;
    logic               wr_block;
    logic [`VRM_DW-1:0] data;
  } vrm_sw_s;

endpackage

/* vrm_regfile.sv */
/*
  General register file: 128 words, combinational reads with the two
  constant registers, writes on the clock edge.
  Assumes write ports later in the list win on equal addresses.
*/
`timescale 1ns/1ps
`include "vrm_regs.svh"

module vrm_regfile
  import vrm_pkg::*;
#(
  parameter int NRD = 16,
  parameter int NWR = 10
) (
  input  wire logic                               i_clk,
  input  wire logic [NRD-1:0][`VRM_RA_W-1:0]      i_raddr,
  input  wire vrm_wb_s [NWR-1:0]                  i_wb,
  output logic      [NRD-1:0][`VRM_DW-1:0]        o_rdata
);

  logic [`VRM_DW-1:0] mem [`VRM_NREGS];

  // ========================================================
  // Read ports
  always_comb begin
    for (int r = 0; r < NRD; r++) begin
      if (i_raddr[r] == `VRM_ZERO_IDX) begin
        o_rdata[r] = `VRM_CONST_ZERO;
      end else if (i_raddr[r] == `VRM_ONE_IDX) begin
        o_rdata[r] = `VRM_CONST_ONE;
      end else begin
        o_rdata[r] = mem[i_raddr[r]];
      end
    end
  end

  // ========================================================
  // Write ports, constant registers never stored
  always_ff @(posedge i_clk) begin
    for (int w = 0; w < NWR; w++) begin
      if (i_wb[w].en && (i_wb[w].addr > `VRM_ONE_IDX)) begin
        mem[i_wb[w].addr] <= i_wb[w].data;
      end
    end
  end

endmodule

/* vrm_slot.sv */
/*
  One operation slot: guard test, add, word load pipeline and
  jump-if-false decision.
  Assumes operands read combinationally and memory data in the same
  cycle as the registered request.
*/
`timescale 1ns/1ps
`include "vrm_regs.svh"

module vrm_slot
  import vrm_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire logic               i_issue,
  input  wire vrm_slot_s          i_slot,
  input  wire logic [`VRM_DW-1:0] i_guard,
  input  wire logic [`VRM_DW-1:0] i_opa,
  input  wire logic [`VRM_DW-1:0] i_opb,
  input  wire logic [`VRM_DW-1:0] i_mem_data,
  output vrm_wb_s                 o_wb_add,
  output vrm_wb_s                 o_wb_ld,
  output vrm_mem_s                o_mem_req,
  output vrm_br_s                 o_br
);

  logic                 exec;
  logic [`VRM_RA_W-1:0] ld_dest;
  logic [`VRM_RA_W-1:0] next_ld_dest;
  vrm_mem_s             next_mem_req;
  vrm_wb_s              next_wb_ld;

  // ========================================================
  // Next state
  always_comb begin
    exec = i_issue && i_guard[0];
    o_wb_add = '0;
    if (exec && (i_slot.op == VRM_IADD)) begin
      o_wb_add.en   = 1'b1;
      o_wb_add.addr = i_slot.dest;
      o_wb_add.data = i_opa + i_opb;
    end
    next_mem_req = '0;
    next_ld_dest = ld_dest;
    if (exec && (i_slot.op == VRM_LDW)) begin
      next_mem_req.valid = 1'b1;
      next_mem_req.addr  = i_opa + i_slot.imm;
      next_ld_dest       = i_slot.dest;
    end
    next_wb_ld = '0;
    if (o_mem_req.valid) begin
      next_wb_ld.en   = 1'b1;
      next_wb_ld.addr = ld_dest;
      next_wb_ld.data = i_mem_data;
    end
    o_br = '0;
    if (exec && (i_slot.op == VRM_JMPF) && !i_opa[0]) begin
      o_br.taken  = 1'b1;
      o_br.target = i_opb;
    end
  end

  // ========================================================
  // Registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mem_req <= '0;
      o_wb_ld   <= '0;
      ld_dest   <= '0;
    end else begin
      o_mem_req <= next_mem_req;
      o_wb_ld   <= next_wb_ld;
      ld_dest   <= next_ld_dest;
    end
  end

endmodule

/* vrm_core_properties.sv */
/*
  Concurrent checks on the ports of vrm_core.
  Assumes it is bound to vrm_core from the testbench top file.
*/
`timescale 1ns/1ps
`include "vrm_regs.svh"

module vrm_core_properties
  import vrm_pkg::*;
#(
  parameter int SLOTS = `VRM_SLOTS
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_stall,
  input  wire vrm_sw_s              i_sw,
  input  wire logic [`VRM_RA_W-1:0] i_dbg_addr,
  input  wire logic [`VRM_DW-1:0]   o_pc,
  input  wire logic [`VRM_DW-1:0]   o_psw,
  input  wire logic [`VRM_DW-1:0]   o_resume_target,
  input  wire logic [`VRM_DW-1:0]   o_block_start,
  input  wire logic [`VRM_TW-1:0]   o_tally_snap,
  input  wire logic [`VRM_TW-1:0]   o_tally_live,
  input  wire logic                 o_jump_done,
  input  wire logic                 o_exc_taken,
  input  wire logic [`VRM_DW-1:0]   o_dbg_data
);
  // ==========================================================
  // Assertions
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_tally_count: assert property (
    $past(i_rstn) && ($past(o_psw[`VRM_PSW_CS_BIT]) || !$past(i_stall))
    |-> o_tally_live == $past(o_tally_live) + 64'h1)
    else $error("tally missed a count");
  a_tally_hold: assert property (
    $past(i_rstn) && !$past(o_psw[`VRM_PSW_CS_BIT]) && $past(i_stall)
    |-> $stable(o_tally_live)) else $error("tally counted a stall");
  a_snap_hold: assert property (
    $past(i_rstn) && !o_jump_done |-> $stable(o_tally_snap))
    else $error("snapshot moved without jump");
  a_snap_take: assert property (
    o_jump_done |-> o_tally_snap == $past(o_tally_live))
    else $error("snapshot not taken");
  a_block_jump: assert property (
    o_jump_done && !$past(i_sw.wr_block) |-> o_block_start == o_pc)
    else $error("block latch missed target");
  a_resume_jump: assert property (
    o_jump_done && !$past(i_sw.wr_resume) |-> o_resume_target == o_pc)
    else $error("resume latch missed target");
  a_exc_vector: assert property (
    o_exc_taken |-> o_pc == `VRM_EXC_VECTOR
    && ($past(i_sw.wr_block) || $stable(o_block_start)))
    else $error("exception jump wrong");
  a_sw_block: assert property (
    $past(i_rstn) && $past(i_sw.wr_block)
    |-> o_block_start == $past(i_sw.data)) else $error("block write lost");
  a_pc_hold: assert property (
    $past(i_rstn) && $past(i_stall) |-> $stable(o_pc))
    else $error("pc moved in stall");
  a_pc_step: assert property (
    $past(i_rstn) && !$past(i_stall) && !o_jump_done && !o_exc_taken
    |-> o_pc == $past(o_pc) + `VRM_INSTR_BYTES) else $error("pc step");
  a_read_zero: assert property (
    $past(i_rstn) && $past(i_dbg_addr) == `VRM_ZERO_IDX
    |-> o_dbg_data == `VRM_CONST_ZERO) else $error("zero reg not zero");
  a_read_one: assert property (
    $past(i_rstn) && $past(i_dbg_addr) == `VRM_ONE_IDX
    |-> o_dbg_data == `VRM_CONST_ONE) else $error("one reg not one");
endmodule

/* vrm_core_test.sv */
/*
  Self-checking testbench of vrm_core with random data.
  Assumes design files and vrm_core_properties.sv are compiled first.
*/
`timescale 1ns/1ps
`include "vrm_regs.svh"

module vrm_core_test
  import vrm_pkg::*;
;
  localparam logic [31:0] KEY = 32'hA5C3_1E07;
  logic             i_clk, i_rstn, i_stall, i_exc_req;
  vrm_slot_s [4:0]  i_instr, ins;
  logic [4:0][31:0] i_mem_data;
  vrm_sw_s          i_sw;
  logic [6:0]       i_dbg_addr;
  vrm_mem_s [4:0]   o_mem_req;
  logic [31:0]      o_pc, o_psw, o_resume_target, o_block_start;
  logic [31:0]      o_dbg_data, pc, v, t, d, rs, bs;
  logic [63:0]      o_tally_snap, o_tally_live, tl;
  logic             o_jump_done, o_exc_taken;
  int               err_count, comparisons, cycles;

  vrm_core #(.SLOTS(5)) u_dut (.i_clk, .i_rstn, .i_instr, .i_stall,
    .i_exc_req, .i_mem_data, .i_sw, .i_dbg_addr, .o_mem_req, .o_pc,
    .o_psw, .o_resume_target, .o_block_start, .o_tally_snap,
    .o_tally_live, .o_jump_done, .o_exc_taken, .o_dbg_data);

  // ==========================================================
  // Memory answers every word address with a keyed pattern
  always_comb begin
    for (int s = 0; s < 5; s++) i_mem_data[s] = o_mem_req[s].addr ^ KEY;
  end

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles > 5000) begin
      err_count++;
      complete_run();
    end
  end

  // ==========================================================
  // Tasks
  task automatic complete_run;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic see(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic vrm_slot_s op(vrm_op_e o, logic [6:0] g, a, b, dst,
                                   logic [31:0] im);
    return '{g, o, a, b, dst, im};
  endfunction

  task automatic cyc(input logic st);
    @(posedge i_clk);
    i_instr <= ins;
    i_stall <= st;
    if (!st) pc = pc + 32'h4;
    ins = '0;
  endtask

  task automatic rd(input logic [6:0] a);
    cyc(1'b1);
    i_dbg_addr <= a;
    @(posedge i_clk);
    #1;
  endtask

  task automatic jmp(input logic exc, cnd, swb);
    t = $urandom & 32'hFFFF_FFFC;
    d = $urandom;
    ins[0] = op(VRM_LDW, 1, 0, 0, 7'd30, t ^ KEY);
    ins[1] = op(VRM_IADD, 1, 0, 0, 7'd40, 0);
    cyc(1'b0);
    cyc(1'b0);
    cyc(1'b0);
    i_exc_req <= exc;
    ins[2] = op(VRM_JMPF, 1, cnd, 30, 0, 0);
    cyc(1'b0);
    for (int k = 0; k < 3; k++) begin
      ins[4] = op(VRM_IADD, 1, 40, 1, 7'd40, 0);
      cyc(1'b0);
      if (k == 1) cyc(1'b1);
      if (k == 2 && swb) i_sw <= '{1'b0, 1'b0, 1'b1, d};
    end
    cyc(1'b1);
    i_sw <= '0;
    i_exc_req <= 1'b0;
    #1;
    if (!cnd) pc = exc ? `VRM_EXC_VECTOR : t;
    if (!cnd) rs = t;
    if (swb) bs = d;
    else if (!cnd && !exc) bs = t;
    see(o_pc, pc);
    see({o_jump_done, o_exc_taken}, cnd ? 2'b00 : {!exc, exc});
    see(o_resume_target, rs);
    see(o_block_start, bs);
    rd(7'd40);
    see(o_dbg_data, 32'h3);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    i_rstn = 1'b0;
    i_stall = 1'b1;
    i_exc_req = 1'b0;
    i_instr = '0;
    ins = '0;
    i_sw = '0;
    i_dbg_addr = '0;
    {pc, rs, bs} = '0;
    void'($urandom(97311));
    repeat (12) @(posedge i_clk);
    see(o_psw, 32'h800);
    see(o_tally_live, 64'h0);
    i_rstn <= 1'b1;
    rd(7'd0);
    see(o_dbg_data, 32'h0);
    rd(7'd1);
    see(o_dbg_data, 32'h1);
    // Never more than two loads, never a constant register as target
    repeat (4) begin
      v = $urandom;
      ins[1] = op(VRM_LDW, 1, 0, 0, 7'd12, v ^ KEY);
      ins[0] = op(VRM_IADD, 1, 0, 0, 7'd16, 0);
      cyc(1'b0);
      cyc(1'b0);
      #1;
      see(o_mem_req[1], {1'b1, v ^ KEY});
      cyc(1'b0);
      ins[0] = op(VRM_IADD, 1, 12, 0, 7'd13, 0);
      cyc(1'b0);
      ins[2] = op(VRM_IADD, 1, 13, 1, 7'd14, 0);
      cyc(1'b0);
      ins[0] = op(VRM_IADD, 1, 14, 1, 7'd15, 0);
      ins[3] = op(VRM_IADD, 1, 14, 1, 7'd14, 0);
      ins[4] = op(VRM_IADD, 0, 14, 14, 7'd16, 0);
      cyc(1'b0);
      rd(7'd13);
      see(o_dbg_data, v);
      rd(7'd15);
      see(o_dbg_data, v + 32'h2);
      rd(7'd14);
      see(o_dbg_data, v + 32'h2);
      rd(7'd16);
      see(o_dbg_data, 32'h0);
      see(o_pc, pc);
    end
    jmp(1'b0, 1'b0, 1'b0);
    jmp(1'b0, 1'b1, 1'b0);
    jmp(1'b1, 1'b0, 1'b0);
    jmp(1'b1, 1'b0, 1'b1);
    jmp(1'b0, 1'b0, 1'b1);
    i_sw <= '{1'b1, 1'b1, 1'b0, 32'h0};
    cyc(1'b1);
    i_sw <= '0;
    repeat (2) cyc(1'b1);
    #1;
    tl = o_tally_live;
    repeat (4) cyc(1'b1);
    #1;
    see(o_tally_live, tl);
    rs = '0;
    see(o_psw, 32'h0);
    see(o_resume_target, rs);
    i_sw <= '{1'b1, 1'b0, 1'b0, 32'h800};
    cyc(1'b0);
    i_sw <= '0;
    repeat (4) cyc(1'b0);
    #1;
    see(o_tally_live, tl + 64'h4);
    see(o_psw, 32'h800);
    complete_run();
  end
endmodule

bind vrm_core vrm_core_properties #(.SLOTS(SLOTS)) u_props (.i_clk,
  .i_rstn, .i_stall, .i_sw, .i_dbg_addr, .o_pc, .o_psw, .o_resume_target,
  .o_block_start, .o_tally_snap, .o_tally_live, .o_jump_done,
  .o_exc_taken, .o_dbg_data);
